// ===== src/rtc_trim_defs.svh
`ifndef RTC_TRIM_DEFS_SVH
`define RTC_TRIM_DEFS_SVH

// register addresses on the internal register port
`define CTRL_ONE_ADDR      4'he
`define TIME_TRIM_ADDR     4'h7
`define TRIM_STATUS_ADDR   4'h8

// reset values
`define CTRL_ONE_RESET     8'h00
`define TIME_TRIM_RESET    8'h00

// field positions
`define TRIM_SEL_BIT       7
`define CTRL_MODE_MSB      2

// control_one low bits selecting 1 Hz pulse mode on the interrupt pin
`define PULSE_1HZ_MODE     3'h3

// oscillator ticks in one nominal second and half of it
`define TICKS_PER_SEC      16'h8000
`define HALF_SEC_TICKS     16'h4000

// correction interval lengths in seconds
`define INTERVAL_FINE      6'h3c
`define INTERVAL_COARSE    6'h14

// correction code landmarks
`define CODE_GAIN_ZERO     7'h01
`define CODE_GAIN_FIRST    7'h02
`define CODE_GAIN_LAST     7'h3f
`define CODE_LOSS_FIRST    7'h42
`define CODE_NEG_BASE      8'h80

`endif

// ===== src/rtc_trim_pkg.sv
package rtc_trim_pkg;

  // trim word as held in the register
  typedef struct packed {
    logic       interval_resolution_select;
    logic [6:0] trim_correction_value;
  } trim_word_t;

  // one access from the serial interface logic
  typedef struct packed {
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : rtc_trim_pkg

// ===== src/pin_sync.sv
`timescale 1ns/100ps

// two-stage synchronisers for asynchronous pins, plus rising-edge pulses
module pin_sync
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // raw pins
  input  wire logic [1:0] pin_in,
  // synchronised levels and rising edges
  output logic      [1:0] level_q,
  output logic      [1:0] rise_q
);

  logic [1:0] meta_q;
  logic [1:0] prev_q;

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_bit
      // first stage feeds only the second stage
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          meta_q[i]  <= 1'b0;
          level_q[i] <= 1'b0;
        end
        else
        begin
          meta_q[i]  <= pin_in[i];
          level_q[i] <= meta_q[i];
        end
      end

      // edge detect on the settled level
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          prev_q[i] <= 1'b0;
          rise_q[i] <= 1'b0;
        end
        else
        begin
          prev_q[i] <= level_q[i];
          rise_q[i] <= level_q[i] & ~prev_q[i];
        end
      end
    end
  endgenerate

endmodule : pin_sync

// ===== src/rtc_time_count_trim.sv
`timescale 1ns/100ps
`include "rtc_trim_defs.svh"

// Function
// [RQ1] trim word: select bit over seven correction bits
// [RQ2] correction bits are signed, negative as 128-N
// [RQ3] positive codes slow count by distance above 01h
// [RQ4] negative codes speed count by distance below 80h
// [RQ5] codes 0, +1, -64, -63 give no correction
// [RQ6] software keeps fine-mode values within -62 to 63
// [RQ7] one second altered per 20 or 60 seconds
// [RQ8] reference clock output never corrected
// [RQ9] 1 Hz pulse output shows the altered period
// [RQ10] software selects 1 Hz pulse mode for measuring
// [RQ11] software writes neutral trim when load-matched
// [RQ12] host avoids frequent asynchronous access
// [RQ13] power-up flag clears trim and control bits
// [RQ14] trim reads back, applies at interval boundary
module rtc_time_count_trim
  import rtc_trim_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // asynchronous pins: 32.768 kHz oscillator and power-up flag
  input  wire logic       osc_in,
  input  wire logic       power_up_flag,
  // register port from the serial interface logic
  input  wire reg_req_t   reg_req,
  output logic      [7:0] rd_data_q,
  // reference clock, seconds carry and interrupt pin enable
  output logic            reference_clock_out,
  output logic            sec_tick_q,
  output logic            int_oe_n_q
);

  logic [1:0]  sync_level;
  logic [1:0]  sync_rise;
  logic        osc_tick;
  logic        power_clear;
  trim_word_t  trim_q;
  trim_word_t  active_trim_q;
  logic [7:0]  ctrl_one_q;
  logic [15:0] tick_cnt_q;
  logic [15:0] sec_len_d;
  logic [5:0]  sec_in_interval_q;
  logic [5:0]  interval_last;
  logic        last_sec;
  logic        sec_end;
  logic        signed [8:0] delta;

  // ticks added to (positive) or removed from (negative) the corrected second
  function automatic logic signed [8:0] trim_delta(input logic [6:0] code);
    logic [6:0] mag;
    mag        = 7'h00;
    trim_delta = 9'sh000;
    // [RQ3] gain: distance above 01h
    if (code >= `CODE_GAIN_FIRST && code <= `CODE_GAIN_LAST)
    begin
      mag        = code - `CODE_GAIN_ZERO;
      trim_delta = $signed({1'b0, mag, 1'b0});
    end
    // [RQ4] loss: distance below 80h
    else if (code >= `CODE_LOSS_FIRST)
    begin
      mag        = 7'(`CODE_NEG_BASE - {1'b0, code});
      trim_delta = -$signed({1'b0, mag, 1'b0});
    end
    // [RQ5] remaining codes 00h, 01h, 40h, 41h leave the second alone
  endfunction : trim_delta

  // synchronise the oscillator and the power-up flag
  pin_sync u_sync
  (
    .clk     (clk),
    .resetn  (resetn),
    .pin_in  ({power_up_flag, osc_in}),
    .level_q (sync_level),
    .rise_q  (sync_rise)
  );

  assign osc_tick    = sync_rise[0];
  assign power_clear = sync_level[1];

  // [RQ8] reference clock is the bare oscillator, no trim path
  assign reference_clock_out = sync_level[0];

  // trim register: holds the word as written
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      trim_q <= `TIME_TRIM_RESET;
    // [RQ13] power-up clears select and correction bits
    else if (power_clear)
      trim_q <= `TIME_TRIM_RESET;
    // [RQ1] select bit in msb, correction bits below
    else if (reg_req.wr && reg_req.addr == `TIME_TRIM_ADDR)
      trim_q <= reg_req.wdata;
  end

  // control register one
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl_one_q <= `CTRL_ONE_RESET;
    // [RQ13] power-up also clears control bits
    else if (power_clear)
      ctrl_one_q <= `CTRL_ONE_RESET;
    else if (reg_req.wr && reg_req.addr == `CTRL_ONE_ADDR)
      ctrl_one_q <= reg_req.wdata;
  end

  // registered read data
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rd_data_q <= 8'h00;
    else
    begin
      unique case (reg_req.addr)
        // [RQ14] last written word reads back
        `TIME_TRIM_ADDR:   rd_data_q <= trim_q;
        `CTRL_ONE_ADDR:    rd_data_q <= ctrl_one_q;
        `TRIM_STATUS_ADDR: rd_data_q <= {active_trim_q.interval_resolution_select, 1'b0, sec_in_interval_q};
        default:           rd_data_q <= 8'h00;
      endcase
    end
  end

  // [RQ7] interval length from the select bit of the word in use
  assign interval_last = (active_trim_q.interval_resolution_select ? `INTERVAL_FINE : `INTERVAL_COARSE)
                         - 6'h01;
  assign last_sec      = (sec_in_interval_q == interval_last);

  // [RQ2] signed decode of the seven correction bits
  assign delta = trim_delta(active_trim_q.trim_correction_value);

  // [RQ7] only the last second of an interval is lengthened or shortened
  assign sec_len_d = last_sec ? (`TICKS_PER_SEC + 16'(delta)) : `TICKS_PER_SEC;
  assign sec_end   = osc_tick && (tick_cnt_q == sec_len_d - 16'h0001);

  // oscillator ticks within the current second
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      tick_cnt_q <= 16'h0000;
    else if (power_clear)
      tick_cnt_q <= 16'h0000;
    else if (sec_end)
      tick_cnt_q <= 16'h0000;
    else if (osc_tick)
      tick_cnt_q <= tick_cnt_q + 16'h0001;
  end

  // seconds within the correction interval
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sec_in_interval_q <= 6'h00;
    else if (power_clear)
      sec_in_interval_q <= 6'h00;
    else if (sec_end)
      sec_in_interval_q <= last_sec ? 6'h00 : sec_in_interval_q + 6'h01;
  end

  // word in use, refreshed only at an interval boundary
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      active_trim_q <= `TIME_TRIM_RESET;
    else if (power_clear)
      active_trim_q <= `TIME_TRIM_RESET;
    // [RQ14] new value takes effect at next boundary
    else if (sec_end && last_sec)
      active_trim_q <= trim_q;
  end

  // seconds carry pulse to the time count
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sec_tick_q <= 1'b0;
    else
      sec_tick_q <= sec_end;
  end

  // interrupt pin: low drive for the first HALF_SEC_TICKS ticks of each second in pulse mode
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      int_oe_n_q <= 1'b1;
    // [RQ9] corrected second stretches or shrinks the 1 Hz period
    else if (ctrl_one_q[`CTRL_MODE_MSB:0] == `PULSE_1HZ_MODE)
      int_oe_n_q <= ~(tick_cnt_q < `HALF_SEC_TICKS);
    else
      int_oe_n_q <= 1'b1;
  end

endmodule : rtc_time_count_trim

// ===== test/rtc_time_count_trim_assertions.sv
`timescale 1ns/100ps
`include "rtc_trim_defs.svh"

// port-level checks of the trim block
module rtc_time_count_trim_checker
  import rtc_trim_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // inputs
  input wire logic       osc_in,
  input wire logic       power_up_flag,
  input wire reg_req_t   reg_req,
  // outputs
  input wire logic [7:0] rd_data_q,
  input wire logic       reference_clock_out,
  input wire logic       sec_tick_q,
  input wire logic       int_oe_n_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  reset_values_a: assert property ($rose(resetn) |-> rd_data_q == 8'h00 && int_oe_n_q && !sec_tick_q)
    else $error("outputs wrong after reset");
  tick_single_a: assert property (sec_tick_q |=> !sec_tick_q)
    else $error("seconds carry longer than one cycle");
  ref_clock_a: assert property ($past(resetn, 2) |-> reference_clock_out == $past(osc_in, 2))
    else $error("reference clock not a plain copy");
  unmapped_read_a: assert property (!(reg_req.addr inside {4'h7, 4'h8, 4'he}) |=> rd_data_q == 8'h00)
    else $error("unmapped read not zero");
  write_readback_a: assert property (!power_up_flag [*3] ##0 reg_req.wr && reg_req.addr inside {4'h7, 4'he}
    ##1 !power_up_flag && !reg_req.wr && reg_req.addr == $past(reg_req.addr) |=> rd_data_q == $past(reg_req.wdata, 2))
    else $error("written byte not read back");
  power_clear_a: assert property (power_up_flag [*4] ##0 reg_req.addr inside {4'h7, 4'he} |=> rd_data_q == 8'h00)
    else $error("power flag did not clear");
  status_range_a: assert property (reg_req.addr == 4'h8 |=> rd_data_q[5:0] < 6'h3c)
    else $error("second index beyond interval");
  power_int_a: assert property (power_up_flag [*4] |=> int_oe_n_q)
    else $error("interrupt pin driven under power flag");
endmodule : rtc_time_count_trim_checker

// ===== test/reg_host.sv
`timescale 1ns/100ps

// host software model on the register port
module reg_host
  import rtc_trim_pkg::*;
(
  // clock
  input  wire logic clk,
  // register requests and check strobe
  output reg_req_t   req,
  output logic [1:0] chk
);
  logic [7:0] exp_q[$];

  initial
  begin
    req = '0;
    chk = 2'h0;
  end

  // one write strobe cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    req = '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clk) #1;
    req.wr = 1'b0;
  endtask : wr

  // read, noting the expected result; k 1 read data, 2 interrupt pin
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [1:0] k);
    @(posedge clk) #1;
    req.addr = a;
    @(posedge clk) #1;
    exp_q.push_back(e);
    chk = k;
    @(posedge clk) #1;
    chk = 2'h0;
  endtask : rd

  // fine range clamp, negative as 128-n
  function automatic logic [7:0] code(input logic sel, input int n);
    if (sel && n < -62)
      n = -62;
    if (sel && n > 63)
      n = 63;
    return {sel, 7'(n)};
  endfunction : code
endmodule : reg_host

// ===== test/test_rtc_time_count_trim.sv
`timescale 1ns/100ps

`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module test_rtc_time_count_trim
  import rtc_trim_pkg::*;
;
  logic       clk;
  logic       resetn;
  logic       osc_in = 1'b0;
  logic       power_up_flag;
  reg_req_t   req;
  logic [1:0] chk;
  logic [7:0] rd_data_q;
  logic       reference_clock_out;
  logic       sec_tick_q;
  logic       int_oe_n_q;
  logic [7:0] exp_v;
  logic [7:0] tv[8] = '{8'h09, 8'h99, 8'h46, 8'h00, 8'h01, 8'h40, 8'h41, 8'h00};
  int         fail_count = 0;
  int         comparisons = 0;
  int         wait_n = 0;

  rtc_time_count_trim dut (.clk(clk), .resetn(resetn), .osc_in(osc_in), .power_up_flag(power_up_flag),
    .reg_req(req), .rd_data_q(rd_data_q), .reference_clock_out(reference_clock_out),
    .sec_tick_q(sec_tick_q), .int_oe_n_q(int_oe_n_q));
  reg_host host (.clk(clk), .req(req), .chk(chk));

  // clock and oscillator pin, one pin edge per clock so a whole second fits the run
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always
  begin
    @(posedge clk);
    #1 osc_in = ~osc_in;
  end

  // monitor takes the oldest note when a result is shown
  always @(negedge clk)
    if (chk != 2'h0)
    begin
      exp_v = host.exp_q.pop_front();
      `CHECK((chk == 2'h1) ? rd_data_q : {7'h00, int_oe_n_q}, exp_v)
    end

  task automatic end_sim;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  initial
  begin
    #400000;
    fail_count++;
    end_sim();
  end

  initial
  begin
    resetn = 1'b0;
    power_up_flag = 1'b0;
    void'($urandom(53));
    tv[7] = host.code(1'b1, int'($urandom_range(140)) - 70);
    repeat (10) @(posedge clk);
    #1 resetn = 1'b1;
    host.rd(4'h7, 8'h00, 2'h1);
    host.rd(4'he, 8'h00, 2'h1);
    // every trim code kind, back to back
    foreach (tv[i])
    begin
      host.wr(4'h7, tv[i]);
      host.rd(4'h7, tv[i], 2'h1);
    end
    host.rd(4'h8, 8'h00, 2'h1);
    host.wr(4'h3, 8'ha5);
    host.rd(4'h3, 8'h00, 2'h1);
    host.wr(4'he, 8'h33);
    host.rd(4'he, 8'h33, 2'h1);
    host.rd(4'he, 8'h00, 2'h2);
    // power flag clears, writes refused
    @(posedge clk) #1 power_up_flag = 1'b1;
    repeat (4) @(posedge clk);
    host.wr(4'h7, 8'h5a);
    @(posedge clk) #1 power_up_flag = 1'b0;
    repeat (4) @(posedge clk);
    host.rd(4'h7, 8'h00, 2'h1);
    host.rd(4'he, 8'h01, 2'h2);
    host.wr(4'h7, host.code(1'b0, 0));
    host.rd(4'h7, 8'h00, 2'h1);
    // fine-mode word written now must wait for the interval boundary
    host.wr(4'h7, 8'h99);
    // host idle while the first second runs
    while (!sec_tick_q && wait_n < 70000)
    begin
      @(negedge clk);
      wait_n++;
    end
    if (!sec_tick_q)
      fail_count++;
    host.rd(4'h8, 8'h01, 2'h1);
    end_sim();
  end
endmodule : test_rtc_time_count_trim

bind rtc_time_count_trim rtc_time_count_trim_checker chk_i (.clk(clk), .resetn(resetn), .osc_in(osc_in),
  .power_up_flag(power_up_flag), .reg_req(reg_req), .rd_data_q(rd_data_q),
  .reference_clock_out(reference_clock_out), .sec_tick_q(sec_tick_q), .int_oe_n_q(int_oe_n_q));
